// [rtl/dahp_pkg.sv]
// Package: constants and carrier types for the dual converter host port
package dahp_pkg;
    localparam int unsigned DATA_W = 12;
    localparam int unsigned CONV_EDGES = 14;
    localparam logic [3:0] CONV_EDGES_M1 = 4'hd;
    localparam logic [3:0] EDGE_CNT_RST = 4'h0;
    localparam logic [11:0] RESULT_RST = 12'h000;
    localparam logic [11:0] CONFIG_RST = 12'h000;
    localparam logic [11:0] CONV_SEED_A = 12'h5a5;
    localparam logic [11:0] CONV_SEED_B = 12'ha5a;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        DAHP_IDLE,
        DAHP_HOLD,
        DAHP_CONVERT
    } dahp_state_t;

    // Host strobes after synchronisation
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic start_n;
        logic ext_clk;
    } dahp_pins_t;

    // Pair of simultaneous results
    typedef struct packed {
        logic [11:0] chan_a;
        logic [11:0] chan_b;
    } dahp_result_t;
endpackage

// [rtl/dahp_sync.sv]
// Two-stage synchroniser with a falling and rising edge detector
`timescale 1ns/10ps
module dahp_sync (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic async_in,
    input wire logic rst_level_in,
    output logic level_out,
    output logic fall_out,
    output logic rise_out
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            meta_q <= rst_level_in;
            sync_q <= rst_level_in;
            last_q <= rst_level_in;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // Edge pulses are one cycle wide
    assign level_out = sync_q;
    assign fall_out = last_q & ~sync_q;
    assign rise_out = ~last_q & sync_q;
endmodule

// [rtl/dahp_top.sv]
// Conversion control and parallel host port of a dual simultaneous converter
`timescale 1ns/10ps
// Contract
// - Falling conversion start edge puts both converters into hold, regardless of clock.
// - Conversion begins on the next rising edge of the external clock.
// - Busy rises once inputs are held and falls when conversion completes.
// - Parallel interface responds only while chip select is low.
// - Chip select high: strobes and data ignored, data outputs released.
// - Read strobe falling edge selects next result; driven only with chip select low.
// - Host word captured on the rising edge of the write strobe.
// - Write strobe edge counts only while chip select is low.
// - Busy falls after the fourteenth external clock rising edge of the conversion.
module dahp_top (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic CONVERSION_START_N_IN,
    input wire logic EXT_CLOCK_IN,
    input wire logic CS_N_IN,
    input wire logic RD_N_IN,
    input wire logic WR_N_IN,
    input wire logic [11:0] DATA_BUS_IN,
    input wire logic [11:0] SAMPLE_A_IN,
    input wire logic [11:0] SAMPLE_B_IN,
    output logic [11:0] DATA_BUS_OUT,
    output logic DATA_BUS_OE_OUT,
    output logic BUSY_OUT,
    output logic HOLD_OUT,
    output logic [11:0] CONFIG_OUT,
    output logic CONFIG_STB_OUT
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    dahp_pkg::dahp_pins_t lvl;
    dahp_pkg::dahp_pins_t fall;
    dahp_pkg::dahp_pins_t rise;
    logic [11:0] data_meta_q;
    logic [11:0] data_sync_q;

    // Strobes reset to their idle high level and the clock to low,
    // so releasing reset on idle pins raises no false edge
    dahp_sync u_cs (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .async_in(CS_N_IN),
        .rst_level_in(1'b1),
        .level_out(lvl.cs_n),
        .fall_out(fall.cs_n),
        .rise_out(rise.cs_n)
    );
    dahp_sync u_rd (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .async_in(RD_N_IN),
        .rst_level_in(1'b1),
        .level_out(lvl.rd_n),
        .fall_out(fall.rd_n),
        .rise_out(rise.rd_n)
    );
    dahp_sync u_wr (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .async_in(WR_N_IN),
        .rst_level_in(1'b1),
        .level_out(lvl.wr_n),
        .fall_out(fall.wr_n),
        .rise_out(rise.wr_n)
    );
    dahp_sync u_cv (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .async_in(CONVERSION_START_N_IN),
        .rst_level_in(1'b1),
        .level_out(lvl.start_n),
        .fall_out(fall.start_n),
        .rise_out(rise.start_n)
    );
    dahp_sync u_ck (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .async_in(EXT_CLOCK_IN),
        .rst_level_in(1'b0),
        .level_out(lvl.ext_clk),
        .fall_out(fall.ext_clk),
        .rise_out(rise.ext_clk)
    );

    // Data lines share the two-stage delay of the strobes, so a word set up
    // before the write strobe rises is stable when the edge is seen
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            data_meta_q <= dahp_pkg::CONFIG_RST;
            data_sync_q <= dahp_pkg::CONFIG_RST;
        end else begin
            data_meta_q <= DATA_BUS_IN;
            data_sync_q <= data_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    dahp_pkg::dahp_state_t state_q;
    logic [3:0] edge_cnt_q;
    dahp_pkg::dahp_result_t held_q;
    dahp_pkg::dahp_result_t result_q;
    dahp_pkg::dahp_result_t samp_meta_q;
    dahp_pkg::dahp_result_t samp_sync_q;

    // Hold is taken on the start edge alone; the external clock only paces conversion
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            state_q <= dahp_pkg::DAHP_IDLE;
            edge_cnt_q <= dahp_pkg::EDGE_CNT_RST;
        end else begin
            unique case (state_q)
                dahp_pkg::DAHP_IDLE: begin
                    if (fall.start_n) begin
                        state_q <= dahp_pkg::DAHP_HOLD;
                    end
                end
                dahp_pkg::DAHP_HOLD: begin
                    if (rise.ext_clk) begin
                        state_q <= dahp_pkg::DAHP_CONVERT;
                        edge_cnt_q <= dahp_pkg::EDGE_CNT_RST;
                    end
                end
                dahp_pkg::DAHP_CONVERT: begin
                    // The starting edge is edge one; finish on edge fourteen
                    if (rise.ext_clk) begin
                        if (edge_cnt_q == dahp_pkg::CONV_EDGES_M1 - 4'h1) begin
                            state_q <= dahp_pkg::DAHP_IDLE;
                        end
                        edge_cnt_q <= edge_cnt_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= dahp_pkg::DAHP_IDLE;
                end
            endcase
        end
    end

    // Channel samples are pins too; the same two stages as the start strobe
    // line them up, so the pair held is the one present as the pin fell
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            samp_meta_q <= '0;
            samp_sync_q <= '0;
        end else begin
            samp_meta_q <= {SAMPLE_A_IN, SAMPLE_B_IN};
            samp_sync_q <= samp_meta_q;
        end
    end

    // Sample both inputs at the hold instant
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            held_q <= '0;
        end else if (state_q == dahp_pkg::DAHP_IDLE && fall.start_n) begin
            held_q <= samp_sync_q;
        end
    end

    // Results become readable only when conversion has finished
    logic conv_done;
    assign conv_done = state_q == dahp_pkg::DAHP_CONVERT && rise.ext_clk
        && edge_cnt_q == dahp_pkg::CONV_EDGES_M1 - 4'h1;

    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            result_q <= {dahp_pkg::RESULT_RST, dahp_pkg::RESULT_RST};
        end else if (conv_done) begin
            result_q <= held_q;
        end
    end

    // Busy tracks hold and conversion
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            BUSY_OUT <= 1'b0;
            HOLD_OUT <= 1'b0;
        end else begin
            BUSY_OUT <= (state_q == dahp_pkg::DAHP_IDLE) ? fall.start_n : !conv_done;
            HOLD_OUT <= (state_q == dahp_pkg::DAHP_IDLE) ? fall.start_n : !conv_done;
        end
    end

    // ------------------------------------------------------------
    // Parallel read path
    // ------------------------------------------------------------
    logic rd_sel_q;

    // Each read edge steps A then B; a fresh result restarts at A.
    // A read racing busy fall is dropped and the bus keeps its last word; the host avoids it.
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            rd_sel_q <= 1'b0;
            DATA_BUS_OUT <= dahp_pkg::RESULT_RST;
        end else begin
            if (conv_done) begin
                rd_sel_q <= 1'b0;
            end else if (fall.rd_n && !lvl.cs_n) begin
                rd_sel_q <= !rd_sel_q;
                // Bit 11 lands on the top data line, bit 0 on line zero
                DATA_BUS_OUT <= rd_sel_q ? result_q.chan_b : result_q.chan_a;
            end
        end
    end

    // Drive only during a selected read; released otherwise
    assign DATA_BUS_OE_OUT = !lvl.cs_n && !lvl.rd_n;

    // ------------------------------------------------------------
    // Parallel write path
    // ------------------------------------------------------------
    // Write edge accepted only with chip select low
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            CONFIG_OUT <= dahp_pkg::CONFIG_RST;
            CONFIG_STB_OUT <= 1'b0;
        end else begin
            CONFIG_STB_OUT <= rise.wr_n && !lvl.cs_n;
            if (rise.wr_n && !lvl.cs_n) begin
                CONFIG_OUT <= data_sync_q;
            end
        end
    end
endmodule

// [verification/dahp_checker_assertions.sv]
// Checker for the converter host port
`timescale 1ns/10ps
module dahp_checker (
    input wire logic CLK_IN, RESETN_IN, CONVERSION_START_N_IN, EXT_CLOCK_IN, CS_N_IN, RD_N_IN, WR_N_IN,
    input wire logic DATA_BUS_OE_OUT, BUSY_OUT, HOLD_OUT, CONFIG_STB_OUT,
    input wire logic [11:0] DATA_BUS_IN, DATA_BUS_OUT, CONFIG_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    logic ext_q;
    logic [4:0] rise_q;
    // Clock rises since the accepted start; raw pin, so lag is covered by the slow clock
    always_ff @(posedge CLK_IN) begin
        ext_q <= EXT_CLOCK_IN;
        if (!RESETN_IN || ($fell(CONVERSION_START_N_IN) && !BUSY_OUT)) rise_q <= 5'h00;
        else if (EXT_CLOCK_IN && !ext_q) rise_q <= rise_q + 5'h01;
    end
    sequence start_s; $fell(CONVERSION_START_N_IN) && !BUSY_OUT; endsequence
    sequence read_s; (!CS_N_IN && !RD_N_IN)[*3]; endsequence
    // Pin seen high, then low three samples back: the synchroniser depth
    sequence pin_fall_s; !$past(CONVERSION_START_N_IN, 3) && $past(CONVERSION_START_N_IN, 4); endsequence
    hold_edge_a: assert property ($rose(HOLD_OUT) |-> pin_fall_s)
        else $error("hold without start edge");
    busy_start_a: assert property (start_s |-> ##[1:5] BUSY_OUT)
        else $error("busy late");
    hold_busy_a: assert property (HOLD_OUT == BUSY_OUT)
        else $error("hold apart from busy");
    busy_len_a: assert property ($fell(BUSY_OUT) |-> rise_q == 5'h0e)
        else $error("wrong edge count");
    oe_off_a: assert property (CS_N_IN[*3] |-> !DATA_BUS_OE_OUT)
        else $error("bus driven");
    oe_on_a: assert property (read_s |-> DATA_BUS_OE_OUT)
        else $error("bus not driven");
    data_step_a: assert property ($changed(DATA_BUS_OUT) |-> !$past(RD_N_IN, 2) && !$past(CS_N_IN, 2))
        else $error("data moved");
    cfg_pulse_a: assert property (CONFIG_STB_OUT |-> ##1 !CONFIG_STB_OUT)
        else $error("strobe long");
    cfg_data_a: assert property (CONFIG_STB_OUT |-> CONFIG_OUT == $past(DATA_BUS_IN, 3))
        else $error("config word wrong");
    cfg_cs_a: assert property (CS_N_IN[*6] |-> !CONFIG_STB_OUT)
        else $error("write taken");
endmodule
bind dahp_top dahp_checker u_chk (.*);

// [verification/dahp_host.sv]
// Host model: start strobe, free external clock, parallel bus
`timescale 1ns/10ps
module dahp_host (
    input wire logic clk_in,
    input wire logic oe_in,
    input wire logic [11:0] bus_in,
    output logic conv_n_out, cs_n_out, rd_n_out, wr_n_out, drv_out, ext_out,
    output logic [11:0] data_out
);
    logic [2:0] div_q = 3'h0;
    assign ext_out = div_q[2];
    // Free clock at an eighth of the system rate, slow enough to sample
    always @(posedge clk_in) div_q <= div_q + 3'h1;
    initial {conv_n_out, cs_n_out, rd_n_out, wr_n_out, drv_out, data_out} = {4'hf, 13'h0000};
    // Start just after a clock rise so no rise races the hold edge
    task automatic start();
        @(posedge clk_in);
        while (div_q != 3'h4) @(posedge clk_in);
        conv_n_out <= 1'b0;
        repeat (3) @(posedge clk_in);
        conv_n_out <= 1'b1;
    endtask
    // Read strobe held until the synchronised answer has settled
    task automatic read(input logic cs_n, output logic [11:0] w, output logic o);
        @(posedge clk_in);
        cs_n_out <= cs_n;
        rd_n_out <= 1'b0;
        repeat (6) @(posedge clk_in);
        w = bus_in;
        o = oe_in;
        rd_n_out <= 1'b1;
        repeat (3) @(posedge clk_in);
        cs_n_out <= 1'b1;
    endtask
    // Data held past the rising strobe for the capture depth
    task automatic write(input logic cs_n, input logic [11:0] v);
        @(posedge clk_in);
        cs_n_out <= cs_n;
        wr_n_out <= 1'b0;
        drv_out <= 1'b1;
        data_out <= v;
        repeat (2) @(posedge clk_in);
        wr_n_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        drv_out <= 1'b0;
        cs_n_out <= 1'b1;
        repeat (3) @(posedge clk_in);
    endtask
endmodule

// [verification/dahp_top_test.sv]
// Self-checking bench for the converter host port
`timescale 1ns/10ps
module dahp_top_test;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic conv_n, ext, cs_n, rd_n, wr_n, drv, oe, busy, hold, stb;
    logic [11:0] hdata, bus, dout, cfg;
    logic [11:0] sa = 12'h000;
    logic [11:0] sb = 12'h000;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    int n_stb = 0;
    always #50 clk = ~clk;
    // Accepted writes, counted one per strobe pulse
    always @(posedge clk) if (stb === 1'b1) n_stb++;
    // Released bus shows the inverse of the last host word, never a stale match
    assign bus = oe ? dout : (drv ? hdata : ~hdata);
    dahp_top u_dut (.CLK_IN(clk), .RESETN_IN(rstn), .CONVERSION_START_N_IN(conv_n), .EXT_CLOCK_IN(ext),
        .CS_N_IN(cs_n), .RD_N_IN(rd_n), .WR_N_IN(wr_n), .DATA_BUS_IN(bus), .SAMPLE_A_IN(sa),
        .SAMPLE_B_IN(sb), .DATA_BUS_OUT(dout), .DATA_BUS_OE_OUT(oe), .BUSY_OUT(busy), .HOLD_OUT(hold),
        .CONFIG_OUT(cfg), .CONFIG_STB_OUT(stb));
    dahp_host u_host (.clk_in(clk), .oe_in(oe), .bus_in(bus), .conv_n_out(conv_n), .cs_n_out(cs_n),
        .rd_n_out(rd_n), .wr_n_out(wr_n), .drv_out(drv), .ext_out(ext), .data_out(hdata));
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 200 && busy !== lvl; i++) @(posedge clk);
        cmp({11'h000, busy}, {11'h000, lvl}, "busy");
    endtask
    // One conversion, channel A input moved after hold, reads in order with a refused one between
    task automatic t_conv();
        logic [11:0] w;
        logic o;
        sa <= 12'h801;
        sb <= 12'h7fe;
        u_host.start();
        wait_busy(1'b1);
        cmp({11'h000, hold}, 12'h001, "hold");
        sa <= 12'h000;
        wait_busy(1'b0);
        u_host.read(1'b0, w, o);
        cmp(w, 12'h801, "chan a");
        u_host.read(1'b1, w, o);
        cmp({11'h000, o}, 12'h000, "oe cs high");
        u_host.read(1'b0, w, o);
        cmp(w, 12'h7fe, "chan b");
        $display("conv test done");
    endtask
    task automatic t_write();
        u_host.write(1'b0, 12'h5c3);
        cmp(cfg, 12'h5c3, "config");
        cmp(n_stb[11:0], 12'h001, "strobe");
        u_host.write(1'b1, 12'h0a6);
        cmp(cfg, 12'h5c3, "config kept");
        cmp(n_stb[11:0], 12'h001, "strobe refused");
        $display("write test done");
    endtask
    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_conv();
        t_write();
        results();
    end
endmodule
